//--- design/acs_pkg.sv
// Purpose: Shared constants and types for the gain and calibration sequencer.
// Assumes: One clock at 250 MHz; conversion periods are counted in clock cycles.
// Notes:   Both ends refer to every item by its package-scoped name.
//
// Overview of operation
// - Gain selectable as 1, 2, 4, 8, 16.
// - Background calibration repeats until mode changes.
// - Other calibrations run once, then normal.
// - Offset and full-scale results readable afterwards.
// - Host may overwrite calibration registers; used.
// - Mode 001 starts self-calibration; ready held high.
// - Shorted-input offset: three periods, four slave.
// - Then full-scale on reference, three periods.
// - Self-calibration end clears mode to 000.
// - Three refill conversions; ready low at end of third.
// - Mode 010 starts system offset calibration.
// - Live-input offset: three periods, four slave.
// - Then mode 000, one conversion, ready low.
// - Host orders system offset before full-scale.
// - Host recalibrates after gain, boost, rate changes.
// - Host calibrates at power-on, environment changes.
// - Boost rate selectable as 1, 2, 4, 8, 16.
// - Mode 101 interleaves offset, gain, conversions.
package acs_pkg;

  // ****************************************************************
  // Command and register layout
  // ****************************************************************
  localparam int CMD_W        = 16;
  localparam int CAL_W        = 24;
  localparam int MODE_LSB     = 0;
  localparam int GAIN_LSB     = 3;
  localparam int BOOST_LSB    = 6;
  localparam int FIELD_W      = 3;
  localparam logic [2:0] SEL_MAX = 3'h4;
  localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;
  localparam logic [CAL_W-1:0] OFS_RESET = 24'h000000;
  localparam logic [CAL_W-1:0] FS_RESET  = 24'h400000;

  // Device register indices on the link.
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_OFS = 2'h1;
  localparam logic [1:0] REG_FS  = 2'h2;
  localparam logic [1:0] REG_STA = 2'h3;

  // Host register map on the software port.
  localparam logic [3:0] HREG_CMD  = 4'h0;
  localparam logic [3:0] HREG_OFS  = 4'h1;
  localparam logic [3:0] HREG_FS   = 4'h2;
  localparam logic [3:0] HREG_STA  = 4'h3;
  localparam logic [3:0] HREG_RDAT = 4'h4;
  localparam logic [3:0] HREG_RSEL = 4'h5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ       = 250;
  localparam int CONV_US       = 1;
  localparam int CONV_CYCLES   = CONV_US * CLK_MHZ;
  localparam int OFS_PERIODS   = 3;
  localparam int OFS_SLAVE     = 4;
  localparam int FS_PERIODS    = 3;
  localparam int REFILL_PERIODS = 3;
  localparam int SETTLE_PERIODS = 1;

  // ****************************************************************
  // Operation modes and input switch positions
  // ****************************************************************
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SELF   = 3'h1;
  localparam logic [2:0] MODE_SYSOFS = 3'h2;
  localparam logic [2:0] MODE_BG     = 3'h5;

  typedef enum logic [1:0] {
    ACS_IN_ANALOG,
    ACS_IN_SHORT,
    ACS_IN_REF
  } acs_input_t;

endpackage

//--- design/acs_link_if.sv
// Purpose: Register link between the host controller and the converter control.
// Assumes: Single clock; a write or read is a one-cycle strobe.
// Notes:   Read data stand in the cycle after the read strobe.
`timescale 1ns/1ps
interface acs_link_if (
  input wire logic clk
);
  logic                     wr;
  logic                     rd;
  logic [1:0]               addr;
  logic [acs_pkg::CAL_W-1:0] wdata;
  logic [acs_pkg::CAL_W-1:0] rdata;
  logic                     result_valid_n;

  modport device (input wr, input rd, input addr, input wdata,
                  output rdata, output result_valid_n);
  modport host   (output wr, output rd, output addr, output wdata,
                  input rdata, input result_valid_n);
endinterface

//--- design/acs_device.sv
// Purpose: Converter control end: command register, calibration sequencer, ready.
// Assumes: Conversion period is a fixed count of clock cycles.
// Notes:   Calibration results are modelled by sampling a converter data input.
`timescale 1ns/1ps
module acs_device #(
  parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES
) (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Register link.
  acs_link_if.device                    link,
  // Converter side.
  input  wire logic                     slave_mode,
  input  wire logic [acs_pkg::CAL_W-1:0] conv_data,
  output      logic [2:0]               input_gain_amp,
  output      logic [2:0]               oversample_boost_rate,
  output      acs_pkg::acs_input_t      input_switch,
  output      logic                     calibrating
);

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ACS_NORMAL,
    ACS_OFS,
    ACS_FS,
    ACS_REFILL,
    ACS_SETTLE
  } acs_state_t;

  acs_state_t                  state;
  logic [acs_pkg::CMD_W-1:0]   cmd;
  logic [acs_pkg::CAL_W-1:0]   ofs_reg;
  logic [acs_pkg::CAL_W-1:0]   fs_reg;
  logic [$clog2(CONV_CYCLES)-1:0] tick_cnt;
  logic [2:0]                  per_cnt;
  logic                        tick;
  logic                        first_bg;
  logic                        period_done;
  logic [2:0]                  mode;
  logic                        mode_write;

  assign tick       = (tick_cnt == ($clog2(CONV_CYCLES))'(CONV_CYCLES - 1));
  assign mode       = cmd[acs_pkg::MODE_LSB +: acs_pkg::FIELD_W];
  assign mode_write = link.wr && (link.addr == acs_pkg::REG_CMD);

  // Conversion period timebase, free running.
  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // Offset phase length: slave mode adds one period, background only the first time.
  always_comb begin
    if (slave_mode && (mode != acs_pkg::MODE_BG || first_bg)) begin
      period_done = (per_cnt == 3'(acs_pkg::OFS_SLAVE - 1));
    end else begin
      period_done = (per_cnt == 3'(acs_pkg::OFS_PERIODS - 1));
    end
  end

  // Command register; the sequencer's clear of the mode field loses to a host write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd <= acs_pkg::CMD_RESET;
    end else if (mode_write) begin
      cmd <= link.wdata[acs_pkg::CMD_W-1:0];
    end else if (tick && per_cnt == 3'(acs_pkg::FS_PERIODS - 1) && state == ACS_FS
                 && mode != acs_pkg::MODE_BG) begin
      cmd[acs_pkg::MODE_LSB +: acs_pkg::FIELD_W] <= acs_pkg::MODE_NORMAL;
    end else if (tick && state == ACS_OFS && period_done && mode == acs_pkg::MODE_SYSOFS) begin
      cmd[acs_pkg::MODE_LSB +: acs_pkg::FIELD_W] <= acs_pkg::MODE_NORMAL;
    end
  end

  // Gain and boost fields saturate at code 4 (x16); codes 0..4 mean 1..16.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_gain_amp        <= '0;
      oversample_boost_rate <= '0;
    end else begin
      input_gain_amp <= (cmd[acs_pkg::GAIN_LSB +: 3] > acs_pkg::SEL_MAX) ?
                        acs_pkg::SEL_MAX : cmd[acs_pkg::GAIN_LSB +: 3];
      oversample_boost_rate <= (cmd[acs_pkg::BOOST_LSB +: 3] > acs_pkg::SEL_MAX) ?
                        acs_pkg::SEL_MAX : cmd[acs_pkg::BOOST_LSB +: 3];
    end
  end

  // Sequencer: phase changes happen on a conversion boundary, except the abort on a command write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= ACS_NORMAL;
      per_cnt  <= '0;
      first_bg <= 1'b1;
    end else if (mode_write) begin
      // A new mode aborts any sequence and starts at the next boundary.
      state    <= ACS_NORMAL;
      per_cnt  <= '0;
      first_bg <= 1'b1;
    end else if (tick) begin
      per_cnt <= per_cnt + 1'b1;
      unique case (state)
        ACS_NORMAL: begin
          per_cnt <= '0;
          if (mode == acs_pkg::MODE_SELF || mode == acs_pkg::MODE_SYSOFS ||
              mode == acs_pkg::MODE_BG) begin
            state <= ACS_OFS;
          end
        end
        ACS_OFS: begin
          if (period_done) begin
            per_cnt  <= '0;
            first_bg <= 1'b0;
            state    <= (mode == acs_pkg::MODE_SYSOFS) ? ACS_SETTLE :
                        (mode == acs_pkg::MODE_BG) ? ACS_REFILL : ACS_FS;
          end
        end
        ACS_FS: begin
          if (per_cnt == 3'(acs_pkg::FS_PERIODS - 1)) begin
            per_cnt <= '0;
            state   <= ACS_REFILL;
          end
        end
        ACS_REFILL: begin
          if (per_cnt == 3'(acs_pkg::REFILL_PERIODS - 1)) begin
            per_cnt <= '0;
            // Background alternates: after offset refill go to gain, after gain refill
            // return to offset; the ready pulse of this boundary marks valid data.
            if (mode == acs_pkg::MODE_BG) begin
              state <= first_bg ? ACS_OFS : ACS_FS;
              first_bg <= ~first_bg;
            end else begin
              state <= ACS_NORMAL;
            end
          end
        end
        ACS_SETTLE: begin
          per_cnt <= '0;
          state   <= ACS_NORMAL;
        end
      endcase
    end
  end

  // Input switch and calibration flag follow the phase. The flag covers only the offset
  // and full-scale phases, so a ready pulse at the end of a refill never overlaps it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_switch <= acs_pkg::ACS_IN_ANALOG;
      calibrating  <= 1'b0;
    end else begin
      calibrating <= (state == ACS_OFS) || (state == ACS_FS);
      if (state == ACS_OFS && mode != acs_pkg::MODE_SYSOFS) begin
        input_switch <= acs_pkg::ACS_IN_SHORT;
      end else if (state == ACS_FS) begin
        input_switch <= acs_pkg::ACS_IN_REF;
      end else begin
        input_switch <= acs_pkg::ACS_IN_ANALOG;
      end
    end
  end

  // Calibration registers: result captured at phase end; host writes take priority.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ofs_reg <= acs_pkg::OFS_RESET;
      fs_reg  <= acs_pkg::FS_RESET;
    end else begin
      if (link.wr && link.addr == acs_pkg::REG_OFS) begin
        ofs_reg <= link.wdata;
      end else if (tick && state == ACS_OFS && period_done && !mode_write) begin
        ofs_reg <= conv_data;
      end
      if (link.wr && link.addr == acs_pkg::REG_FS) begin
        fs_reg <= link.wdata;
      end else if (tick && state == ACS_FS && !mode_write &&
                   per_cnt == 3'(acs_pkg::FS_PERIODS - 1)) begin
        fs_reg <= conv_data;
      end
    end
  end

  // Read port, data in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.rdata <= '0;
    end else if (link.rd) begin
      unique case (link.addr)
        acs_pkg::REG_CMD: link.rdata <= acs_pkg::CAL_W'(cmd);
        acs_pkg::REG_OFS: link.rdata <= ofs_reg;
        acs_pkg::REG_FS:  link.rdata <= fs_reg;
        acs_pkg::REG_STA: link.rdata <= acs_pkg::CAL_W'({state != ACS_NORMAL, 2'(input_switch)});
      endcase
    end
  end

  // Ready pulses low for one cycle at each boundary with valid data only: every normal
  // period, the boundary that ends the settle period and the one that ends a refill.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.result_valid_n <= 1'b1;
    end else begin
      link.result_valid_n <= ~(tick && !mode_write &&
                               (((state == ACS_NORMAL || state == ACS_SETTLE) &&
                                 mode == acs_pkg::MODE_NORMAL) ||
                                (state == ACS_REFILL &&
                                 per_cnt == 3'(acs_pkg::REFILL_PERIODS - 1))));
    end
  end

endmodule

//--- design/acs_host.sv
// Purpose: Host end: turns software register accesses into link transfers.
// Assumes: Software port strobes are one cycle and never both at once.
// Notes:   Link reads land in a host register two cycles after the strobe.
`timescale 1ns/1ps
module acs_host (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Software port.
  input  wire logic [3:0]               sw_addr,
  input  wire logic [acs_pkg::CAL_W-1:0] sw_wdata,
  input  wire logic                     sw_wr,
  input  wire logic                     sw_rd,
  output      logic [acs_pkg::CAL_W-1:0] sw_rdata,
  output      logic                     ready_seen,
  // Link.
  acs_link_if.host                      link
);

  logic [acs_pkg::CAL_W-1:0] rd_hold;
  logic                      rd_pend;

  // Writes to device-mapped offsets pass straight to the link; software sequences
  // calibrations, offset before full-scale, and recalibrates after setting changes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.wr    <= 1'b0;
      link.rd    <= 1'b0;
      link.addr  <= '0;
      link.wdata <= '0;
    end else begin
      link.wr    <= sw_wr && sw_addr <= acs_pkg::HREG_STA;
      link.rd    <= sw_wr && sw_addr == acs_pkg::HREG_RSEL;
      link.addr  <= sw_wr ? ((sw_addr == acs_pkg::HREG_RSEL) ? sw_wdata[1:0] : sw_addr[1:0])
                          : link.addr;
      link.wdata <= sw_wr ? sw_wdata : link.wdata;
    end
  end

  // Captured link read data and ready observation.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pend    <= 1'b0;
      rd_hold    <= '0;
      ready_seen <= 1'b0;
    end else begin
      rd_pend <= link.rd;
      if (rd_pend) begin
        rd_hold <= link.rdata;
      end
      // Set wins over a clear by a read of the data register.
      if (!link.result_valid_n) begin
        ready_seen <= 1'b1;
      end else if (sw_rd && sw_addr == acs_pkg::HREG_RDAT) begin
        ready_seen <= 1'b0;
      end
    end
  end

  // Software read port.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_rdata <= '0;
    end else if (sw_rd) begin
      sw_rdata <= (sw_addr == acs_pkg::HREG_RDAT) ? rd_hold :
                  (sw_addr == acs_pkg::HREG_STA) ? acs_pkg::CAL_W'({rd_pend, ready_seen}) :
                  '0;
    end
  end

endmodule

//--- tb/acs_assertions.sv
// Purpose: Concurrent checks on the link between host and converter control.
// Assumes: Conversion boundaries run free at CONV_CYCLES clocks; slave_mode steady in a run.
// Notes:   Watch windows allow one conversion period plus one clock of slack above the earliest pulse.
`timescale 1ns/1ps
module acs_assertions #(
  parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES
) (
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      rst_n,
  // Link.
  input wire logic                      wr,
  input wire logic                      rd,
  input wire logic [1:0]                addr,
  input wire logic [acs_pkg::CAL_W-1:0] wdata,
  input wire logic [acs_pkg::CAL_W-1:0] rdata,
  input wire logic                      result_valid_n,
  // Converter side.
  input wire logic                      slave_mode,
  input wire logic                      calibrating,
  input wire acs_pkg::acs_input_t       input_switch
);
  localparam int C = CONV_CYCLES;
  logic [2:0] lmode;
  logic       active;
  int         run;
  int         since;
  int         lo;
  int         hi;
  wire        pulse = !result_valid_n;

  // A command write opens a watch window that the next ready pulse closes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lmode  <= acs_pkg::MODE_NORMAL;
      active <= 1'b0;
      run    <= 0;
    end else if (wr && addr == acs_pkg::REG_CMD) begin
      lmode  <= wdata[2:0];
      active <= 1'b1;
      run    <= 1;
    end else begin
      active <= active && !pulse;
      run    <= run + 1;
    end
  end

  // Clocks since the previous pulse; zero until the first one.
  always_ff @(posedge clk) begin
    if (!rst_n || pulse) begin
      since <= rst_n ? 1 : 0;
    end else if (since != 0) begin
      since <= since + 1;
    end
  end

  // Earliest and latest pulse after a mode write; slave mode adds one offset period.
  always_comb begin
    case (lmode)
      acs_pkg::MODE_SELF:   lo = 9 * C;
      acs_pkg::MODE_SYSOFS: lo = 4 * C;
      acs_pkg::MODE_BG:     lo = 6 * C;
      default:              lo = 0;
    endcase
    if (slave_mode && lo != 0) begin
      lo = lo + C;
    end
    hi = (lo == 0) ? 32'h7FFFFFFF : lo + C + 1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pulse_width_a: assert property ($fell(result_valid_n) |=> result_valid_n)
    else $error("ready pulse longer than one clock");
  normal_rate_a: assert property (pulse && !active && since != 0 && lmode != acs_pkg::MODE_BG
    |-> since == C) else $error("normal ready spacing wrong");
  bg_repeat_a: assert property (pulse && !active && since != 0 && lmode == acs_pkg::MODE_BG
    |-> since == 6 * C) else $error("background cycle spacing wrong");
  cal_early_a: assert property (pulse && active && lo != 0 |-> run >= lo)
    else $error("ready pulse came too early after calibration start");
  cal_late_a: assert property (active |-> run <= hi)
    else $error("calibration did not finish in time");
  quiet_cal_a: assert property (calibrating |-> result_valid_n)
    else $error("ready pulsed during calibration");
  idle_analog_a: assert property (!calibrating |-> input_switch == acs_pkg::ACS_IN_ANALOG)
    else $error("input not on analog outside calibration");
  live_input_a: assert property (active && lmode == acs_pkg::MODE_SYSOFS
    |-> input_switch == acs_pkg::ACS_IN_ANALOG) else $error("system offset shorted input");
  short_then_ref_a: assert property ($fell(input_switch == acs_pkg::ACS_IN_SHORT)
    && lmode == acs_pkg::MODE_SELF |-> input_switch == acs_pkg::ACS_IN_REF)
    else $error("offset phase not followed by reference phase");
  rdata_hold_a: assert property (!$past(rd) |-> $stable(rdata))
    else $error("read data moved without a read");

  self_done_c: cover property (pulse && active && lmode == acs_pkg::MODE_SELF);
  sysofs_done_c: cover property (pulse && active && lmode == acs_pkg::MODE_SYSOFS);
  bg_loop_c: cover property (pulse && !active && since != 0 && lmode == acs_pkg::MODE_BG);
endmodule

//--- tb/acs_test.sv
// Purpose: Drives the host software port and checks the calibration sequencer end to end.
// Assumes: Short conversion period of 10 clocks.
// Notes:   Device registers are read through the host select and data registers.
`timescale 1ns/1ps
module acs_test;
  localparam int C = 10;
  localparam int W = acs_pkg::CAL_W;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               slave_mode = 1'b0;
  logic [W-1:0]       conv_data = '0;
  logic [3:0]         sw_addr = '0;
  logic [W-1:0]       sw_wdata = '0;
  logic               sw_wr = 1'b0;
  logic               sw_rd = 1'b0;
  logic [W-1:0]       sw_rdata;
  logic [2:0]         input_gain_amp;
  logic [2:0]         oversample_boost_rate;
  logic               calibrating;
  acs_pkg::acs_input_t input_switch;
  logic [W-1:0]       d;
  int                 err_total = 0;
  int                 compares = 0;
  int                 cycles = 0;

  always #2 clk = ~clk;

  acs_link_if link (.clk(clk));
  acs_device #(.CONV_CYCLES(C)) acs_device_inst (.clk(clk), .rst_n(rst_n), .link(link),
    .slave_mode(slave_mode), .conv_data(conv_data), .input_gain_amp(input_gain_amp),
    .oversample_boost_rate(oversample_boost_rate), .input_switch(input_switch),
    .calibrating(calibrating));
  acs_host acs_host_inst (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ready_seen(), .link(link));
  acs_assertions #(.CONV_CYCLES(C)) acs_assertions_inst (.clk(clk), .rst_n(rst_n),
    .wr(link.wr), .rd(link.rd), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .result_valid_n(link.result_valid_n), .slave_mode(slave_mode),
    .calibrating(calibrating), .input_switch(input_switch));

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // A hung wait must not stall the run forever.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      tally_and_finish;
    end
  end

  task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The trailing edge keeps two strobes from being set in one time step.
  task automatic sw_write(input logic [3:0] a, input logic [W-1:0] v);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic sw_read(input logic [3:0] a, output logic [W-1:0] v);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
    @(posedge clk);
  endtask

  task automatic read_check(input logic [1:0] r, input logic [W-1:0] exp);
    logic [W-1:0] v;
    sw_write(acs_pkg::HREG_RSEL, W'(r));
    repeat (3) @(posedge clk);
    sw_read(acs_pkg::HREG_RDAT, v);
    check(v, exp);
  endtask

  // Waits for a ready pulse under a bound, then steps past it.
  task automatic wait_pulse(input int lim);
    int n;
    n = 0;
    #1;
    while (link.result_valid_n !== 1'b0 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    check(W'(n < lim), W'(1));
    @(posedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    read_check(acs_pkg::REG_CMD, W'(acs_pkg::CMD_RESET));
    read_check(acs_pkg::REG_OFS, acs_pkg::OFS_RESET);
    read_check(acs_pkg::REG_FS, acs_pkg::FS_RESET);
    sw_read(4'hF, d);
    check(d, '0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      sw_write(acs_pkg::HREG_CMD, W'({3'(7 - i), 3'(i), 3'h0}));
      repeat (2) @(posedge clk);
      #1 check(W'(input_gain_amp), W'(i > 4 ? acs_pkg::SEL_MAX : 3'(i)));
      check(W'(oversample_boost_rate), W'(7 - i > 4 ? acs_pkg::SEL_MAX : 3'(7 - i)));
      @(posedge clk);
    end
    $display("test gain done");
    conv_data <= 24'h123456;
    sw_write(acs_pkg::HREG_CMD, W'(acs_pkg::MODE_SELF));
    wait_pulse(12 * C);
    read_check(acs_pkg::REG_CMD, W'(acs_pkg::MODE_NORMAL));
    read_check(acs_pkg::REG_OFS, 24'h123456);
    read_check(acs_pkg::REG_FS, 24'h123456);
    sw_write(acs_pkg::HREG_OFS, 24'hABCDEF);
    sw_write(acs_pkg::HREG_FS, 24'h3C3C3C);
    read_check(acs_pkg::REG_OFS, 24'hABCDEF);
    read_check(acs_pkg::REG_FS, 24'h3C3C3C);
    $display("test self calibration done");
    slave_mode <= 1'b1;
    conv_data <= 24'h0F0F0F;
    sw_write(acs_pkg::HREG_CMD, W'(acs_pkg::MODE_SYSOFS));
    wait_pulse(8 * C);
    slave_mode <= 1'b0;
    read_check(acs_pkg::REG_CMD, W'(acs_pkg::MODE_NORMAL));
    read_check(acs_pkg::REG_OFS, 24'h0F0F0F);
    read_check(acs_pkg::REG_FS, 24'h3C3C3C);
    $display("test system offset done");
    conv_data <= 24'h00AA55;
    sw_write(acs_pkg::HREG_CMD, W'(acs_pkg::MODE_BG));
    repeat (3) wait_pulse(8 * C);
    read_check(acs_pkg::REG_CMD, W'(acs_pkg::MODE_BG));
    read_check(acs_pkg::REG_OFS, 24'h00AA55);
    sw_write(acs_pkg::HREG_CMD, W'(acs_pkg::MODE_NORMAL));
    wait_pulse(8 * C);
    wait_pulse(2 * C);
    sw_read(acs_pkg::HREG_STA, d);
    check(d, W'(1));
    $display("test background done");
    tally_and_finish;
  end
endmodule
